/* File: rtl/flash_prot_ctrl.sv */
// chip-level flash protection mode controller and access gate
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RULE1] factory state open, debug unrestricted
// [RULE2] open may move to protected on request
// [RULE3] protected refuses external debug accesses
// [RULE4] protected returns open only after full erase
// [RULE5] open may move directly to kill
// [RULE6] kill blocks every debug access
// [RULE7] kill rejects any external erase
// [RULE8] kill is permanent, no way out
// [RULE9] row write and read protection enforced
// [RULE10] internal system calls always reach flash; here row protection, and kill mode for a full erase, still refuse them
// [RULE11] fetches complete with zero wait cycles
// [RULE12] mode reloaded from nonvolatile before debug
module flash_prot_ctrl (
	input  wire logic                                  i_clk,
	input  wire logic                                  i_rst_n,
	// nonvolatile mode storage
	input  wire logic [1:0]                            i_nv_mode,
	input  wire logic                                  i_nv_ready,
	output logic                                       o_nv_rd_req,
	output logic                                       o_nv_wr_req,
	output logic [1:0]                                 o_nv_wr_mode,
	// mode change requests
	input  wire logic                                  i_req_protect,
	input  wire logic                                  i_req_kill,
	input  wire logic                                  i_req_open,
	input  wire logic                                  i_req_internal,
	// row protection setup (internal only)
	input  wire logic                                  i_row_set,
	input  wire logic [flash_prot_pkg::ROW_BITS-1:0]   i_row_set_idx,
	input  wire logic                                  i_row_set_rd,
	input  wire logic                                  i_row_set_wr,
	// flash access requests
	input  wire logic                                  i_acc_valid,
	input  wire logic                                  i_acc_debug,
	input  wire logic                                  i_acc_syscall,
	input  wire logic                                  i_acc_write,
	input  wire logic                                  i_acc_erase_all,
	input  wire logic [flash_prot_pkg::ADDR_BITS-1:0]  i_acc_addr,
	input  wire logic [31:0]                           i_flash_rdata,
	// fetch path
	input  wire logic                                  i_fetch_valid,
	input  wire logic [flash_prot_pkg::ADDR_BITS-1:0]  i_fetch_addr,
	output logic                                       o_fetch_valid,
	output logic [31:0]                                o_fetch_data,
	// flash array control
	output logic                                       o_flash_rd,
	output logic                                       o_flash_wr,
	output logic                                       o_flash_erase_row,
	output logic [flash_prot_pkg::ADDR_BITS-1:0]       o_flash_addr,
	// results and status
	output logic                                       o_acc_grant,
	output logic                                       o_acc_refused,
	output logic [31:0]                                o_rd_data,
	output logic [1:0]                                 o_mode,
	output logic                                       o_debug_enable,
	output logic                                       o_mode_valid,
	output logic                                       o_req_rejected,
	output logic [1:0]                                 o_flash_wait_cycles
);

	////////////////////////////////////////////////////////////////////////////
	// state

	flash_prot_pkg::prot_mode_t  mode_reg;
	flash_prot_pkg::prot_mode_t  target_reg;
	flash_prot_pkg::ctrl_state_t state_reg;
	logic [9:0]                  erase_row_reg;
	logic                        mode_valid_reg;
	logic                        row_rd_blk;
	logic                        row_wr_blk;
	logic                        row_clear;
	logic                        internal_ok;
	logic                        debug_ok;
	logic                        acc_ok;
	logic                        erase_ok;
	logic                        erase_go;

	////////////////////////////////////////////////////////////////////////////
	// access decision

	// syscalls bypass the mode gate, except for a full erase in kill, but still honour row protection
	assign internal_ok = i_acc_syscall && !i_acc_debug; // RULE10
	assign debug_ok    = i_acc_debug && mode_valid_reg
		&& (mode_reg == flash_prot_pkg::MODE_OPEN); // RULE3 RULE6 RULE12
	assign erase_ok    = i_acc_erase_all && (mode_reg != flash_prot_pkg::MODE_KILL)
		&& (internal_ok || debug_ok || (i_acc_debug && mode_valid_reg
		&& mode_reg == flash_prot_pkg::MODE_PROTECTED)); // RULE4 RULE7
	assign acc_ok      = (internal_ok || debug_ok) && !i_acc_erase_all
		&& !(i_acc_write ? row_wr_blk : row_rd_blk); // RULE9
	assign erase_go    = i_acc_valid && erase_ok && (state_reg == flash_prot_pkg::ST_RUN);
	assign row_clear   = (state_reg == flash_prot_pkg::ST_ERASE)
		&& (erase_row_reg == flash_prot_pkg::ERASE_ROW_LAST);

	row_prot_check u_rows (
		.i_clk         (i_clk),
		.i_rst_n       (i_rst_n),
		.i_set_we      (i_row_set && i_req_internal),
		.i_set_row     (i_row_set_idx),
		.i_set_rd_prot (i_row_set_rd),
		.i_set_wr_prot (i_row_set_wr),
		.i_clear_all   (row_clear),
		.i_row         (i_acc_addr[flash_prot_pkg::ADDR_BITS-1:flash_prot_pkg::ROW_LSB]),
		.o_rd_blocked  (row_rd_blk),
		.o_wr_blocked  (row_wr_blk)
	);

	////////////////////////////////////////////////////////////////////////////
	// mode sequencer

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg      <= flash_prot_pkg::ST_LOAD;
			mode_reg       <= flash_prot_pkg::MODE_OPEN; // RULE1
			target_reg     <= flash_prot_pkg::MODE_OPEN;
			mode_valid_reg <= 1'b0;
			erase_row_reg  <= flash_prot_pkg::ERASE_ROW_FIRST;
		end else begin
			case (state_reg)
				flash_prot_pkg::ST_LOAD: begin
					state_reg <= flash_prot_pkg::ST_WAIT_NV;
				end
				flash_prot_pkg::ST_WAIT_NV: begin
					if (i_nv_ready) begin
						// unknown code fails safe to the strictest mode
						if (i_nv_mode == flash_prot_pkg::MODE_RSVD)
							mode_reg <= flash_prot_pkg::MODE_KILL;
						else
							mode_reg <= flash_prot_pkg::prot_mode_t'(i_nv_mode); // RULE12
						mode_valid_reg <= 1'b1; // RULE12
						state_reg      <= flash_prot_pkg::ST_RUN;
					end
				end
				flash_prot_pkg::ST_RUN: begin
					if (erase_go) begin
						erase_row_reg <= flash_prot_pkg::ERASE_ROW_FIRST;
						state_reg     <= flash_prot_pkg::ST_ERASE;
					end else if (mode_reg == flash_prot_pkg::MODE_OPEN && i_req_kill) begin
						target_reg <= flash_prot_pkg::MODE_KILL; // RULE5
						state_reg  <= flash_prot_pkg::ST_PROG_NV;
					end else if (mode_reg == flash_prot_pkg::MODE_OPEN && i_req_protect) begin
						target_reg <= flash_prot_pkg::MODE_PROTECTED; // RULE2
						state_reg  <= flash_prot_pkg::ST_PROG_NV;
					end
				end
				flash_prot_pkg::ST_ERASE: begin
					if (erase_row_reg == flash_prot_pkg::ERASE_ROW_LAST) begin
						// only a completed full erase reopens the part
						if (mode_reg == flash_prot_pkg::MODE_PROTECTED) begin
							target_reg <= flash_prot_pkg::MODE_OPEN; // RULE4
							state_reg  <= flash_prot_pkg::ST_PROG_NV;
						end else begin
							state_reg <= flash_prot_pkg::ST_RUN;
						end
					end else begin
						erase_row_reg <= erase_row_reg + 10'h001;
					end
				end
				flash_prot_pkg::ST_PROG_NV: begin
					if (i_nv_ready) begin
						if (mode_reg != flash_prot_pkg::MODE_KILL)
							mode_reg <= target_reg; // RULE8
						state_reg <= flash_prot_pkg::ST_RUN;
					end
				end
				default: begin
					state_reg <= flash_prot_pkg::ST_LOAD;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// nonvolatile handshake and request rejection

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_nv_rd_req    <= 1'b0;
			o_nv_wr_req    <= 1'b0;
			o_nv_wr_mode   <= flash_prot_pkg::MODE_OPEN;
			o_req_rejected <= 1'b0;
		end else begin
			o_nv_rd_req  <= (state_reg == flash_prot_pkg::ST_LOAD)
				|| (state_reg == flash_prot_pkg::ST_WAIT_NV && !i_nv_ready);
			o_nv_wr_req  <= (state_reg == flash_prot_pkg::ST_PROG_NV) && !i_nv_ready;
			o_nv_wr_mode <= target_reg;
			// open without erase, or any change out of kill, is rejected
			o_req_rejected <= (state_reg == flash_prot_pkg::ST_RUN) && !erase_go && (
				(i_req_open && mode_reg != flash_prot_pkg::MODE_OPEN) // RULE4 RULE8
				|| ((i_req_protect || i_req_kill) && mode_reg != flash_prot_pkg::MODE_OPEN)
				|| (i_acc_valid && i_acc_erase_all && !erase_ok)); // RULE7
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// flash access gating

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_acc_grant       <= 1'b0;
			o_acc_refused     <= 1'b0;
			o_flash_rd        <= 1'b0;
			o_flash_wr        <= 1'b0;
			o_flash_erase_row <= 1'b0;
			o_flash_addr      <= '0;
			o_rd_data         <= flash_prot_pkg::RESET_DATA;
		end else begin
			o_acc_grant   <= 1'b0;
			o_acc_refused <= 1'b0;
			o_flash_rd    <= 1'b0;
			o_flash_wr    <= 1'b0;
			o_flash_erase_row <= (state_reg == flash_prot_pkg::ST_ERASE);
			if (state_reg == flash_prot_pkg::ST_ERASE)
				o_flash_addr <= {erase_row_reg[flash_prot_pkg::ROW_BITS-1:0],
					{flash_prot_pkg::ROW_LSB{1'b0}}};
			else if (i_acc_valid && acc_ok && state_reg == flash_prot_pkg::ST_RUN)
				o_flash_addr <= i_acc_addr;
			if (i_acc_valid && state_reg == flash_prot_pkg::ST_RUN && !i_acc_erase_all) begin
				o_acc_grant   <= acc_ok; // RULE3 RULE6 RULE9 RULE10
				o_acc_refused <= !acc_ok;
				o_flash_rd    <= acc_ok && !i_acc_write;
				o_flash_wr    <= acc_ok && i_acc_write;
			end
			// refused reads return zero so nothing leaks
			o_rd_data <= (o_flash_rd) ? i_flash_rdata : flash_prot_pkg::RESET_DATA;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cpu fetch path, no wait states

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fetch_valid       <= 1'b0;
			o_fetch_data        <= flash_prot_pkg::RESET_DATA;
			o_flash_wait_cycles <= flash_prot_pkg::FLASH_WAIT_CYCLES;
		end else begin
			// array answers combinationally, so one edge per fetch
			o_fetch_valid       <= i_fetch_valid; // RULE11
			o_fetch_data        <= i_flash_rdata; // RULE11
			o_flash_wait_cycles <= flash_prot_pkg::FLASH_WAIT_CYCLES; // RULE11
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status outputs

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mode         <= flash_prot_pkg::MODE_OPEN;
			o_debug_enable <= 1'b0;
			o_mode_valid   <= 1'b0;
		end else begin
			o_mode         <= mode_reg;
			o_debug_enable <= mode_valid_reg && (mode_reg == flash_prot_pkg::MODE_OPEN); // RULE12
			o_mode_valid   <= mode_valid_reg;
		end
	end

endmodule // flash_prot_ctrl

`default_nettype wire

/* File: rtl/flash_prot_pkg.sv */
// constants and types shared by the flash protection controller
package flash_prot_pkg;

	// protection mode encodings as held in nonvolatile storage
	typedef enum logic [1:0] {
		MODE_OPEN      = 2'h0,
		MODE_PROTECTED = 2'h1,
		MODE_KILL      = 2'h2,
		MODE_RSVD      = 2'h3
	} prot_mode_t;

	// controller sequencing states
	typedef enum logic [2:0] {
		ST_LOAD    = 3'h0,
		ST_WAIT_NV = 3'h1,
		ST_RUN     = 3'h2,
		ST_ERASE   = 3'h3,
		ST_PROG_NV = 3'h4
	} ctrl_state_t;

	localparam int          ROW_BITS           = 9;
	localparam int          NUM_ROWS           = 512;
	localparam int          ADDR_BITS          = 15;
	localparam int          ROW_LSB            = 6;
	localparam int          CLK_HZ             = 20000000;
	localparam int          MAX_FETCH_HZ       = 24000000;
	// flash wait cycles stays zero at and below the fastest fetch clock
	localparam logic [1:0]  FLASH_WAIT_CYCLES  = 2'h0;
	localparam logic [9:0]  ERASE_ROW_LAST     = 10'h1ff;
	localparam logic [9:0]  ERASE_ROW_FIRST    = 10'h000;
	localparam logic [31:0] RESET_DATA         = 32'h0000_0000;

endpackage : flash_prot_pkg

/* File: rtl/row_prot_check.sv */
// per-row read and write protection lookup
`timescale 1ns/1ns
`default_nettype none

module row_prot_check (
	input  wire logic                                 i_clk,
	input  wire logic                                 i_rst_n,
	input  wire logic                                 i_set_we,
	input  wire logic [flash_prot_pkg::ROW_BITS-1:0]  i_set_row,
	input  wire logic                                 i_set_rd_prot,
	input  wire logic                                 i_set_wr_prot,
	input  wire logic                                 i_clear_all,
	input  wire logic [flash_prot_pkg::ROW_BITS-1:0]  i_row,
	output logic                                      o_rd_blocked,
	output logic                                      o_wr_blocked
);

	logic [flash_prot_pkg::NUM_ROWS-1:0] rd_prot_reg;
	logic [flash_prot_pkg::NUM_ROWS-1:0] wr_prot_reg;

	// full erase wipes the row protection map with the array
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_prot_reg <= '0;
			wr_prot_reg <= '0;
		end else if (i_clear_all) begin
			rd_prot_reg <= '0;
			wr_prot_reg <= '0;
		end else if (i_set_we) begin
			rd_prot_reg[i_set_row] <= i_set_rd_prot;
			wr_prot_reg[i_set_row] <= i_set_wr_prot;
		end
	end

	assign o_rd_blocked = rd_prot_reg[i_row];
	assign o_wr_blocked = wr_prot_reg[i_row];

endmodule // row_prot_check

`default_nettype wire

/* File: bench/flash_nv_model.sv */
// behavioural nonvolatile store that answers mode load and program requests
`timescale 1ns/1ns
`default_nettype none

module flash_nv_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [3:0] i_dly,
	input  wire logic       i_rd_req,
	input  wire logic       i_wr_req,
	input  wire logic [1:0] i_wr_mode,
	output logic [1:0]      o_mode,
	output logic            o_ready
);
	logic [1:0] stored_reg;
	logic [3:0] cnt_reg;
	logic       done;

	initial stored_reg = 2'h0;
	assign o_mode = stored_reg;
	assign done = (cnt_reg == i_dly);

	// handshake restarts on reset, the stored mode does not
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= 4'h0;
			o_ready <= 1'h0;
		end else if ((i_rd_req || i_wr_req) && !o_ready) begin
			o_ready <= done;
			cnt_reg <= done ? 4'h0 : cnt_reg + 4'h1;
		end else begin
			cnt_reg <= 4'h0;
			o_ready <= 1'h0;
		end
	end

	always @(posedge i_clk) begin
		if (i_rst_n && i_wr_req && !o_ready && done) begin
			stored_reg <= i_wr_mode;
		end
	end
endmodule // flash_nv_model

`default_nettype wire

/* File: bench/flash_prot_ctrl_asserts.sv */
// concurrent checks on the flash protection controller ports
`timescale 1ns/1ns
`default_nettype none

module flash_prot_ctrl_asserts (
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	input wire logic       i_acc_valid,
	input wire logic       i_acc_debug,
	input wire logic       i_fetch_valid,
	input wire logic       o_fetch_valid,
	input wire logic       o_acc_grant,
	input wire logic [1:0] o_mode,
	input wire logic       o_mode_valid,
	input wire logic       o_debug_enable,
	input wire logic       o_flash_erase_row,
	input wire logic [1:0] o_flash_wait_cycles
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	////////////////////////////////////////////////////////////////
	logic [9:0] erase_cnt_reg;
	logic [1:0] prev_mode_reg;
	logic       full_reg;

	// full_reg: a whole sweep seen since protected was last entered
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			erase_cnt_reg <= 10'h000;
			prev_mode_reg <= 2'h0;
			full_reg      <= 1'h0;
		end else begin
			erase_cnt_reg <= o_flash_erase_row ? erase_cnt_reg + 10'h001 : 10'h000;
			prev_mode_reg <= o_mode;
			if (o_flash_erase_row && erase_cnt_reg == 10'h1ff)
				full_reg <= 1'h1;
			else if (o_mode == 2'h1 && prev_mode_reg != 2'h1)
				full_reg <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////
	a_fetch_no_wait: assert property (i_fetch_valid |=> o_fetch_valid)
		else $error("fetch not answered next cycle");
	a_wait_cycles_zero: assert property (o_flash_wait_cycles == 2'h0)
		else $error("flash wait cycles not zero");
	a_prot_debug_refused: assert property (
		o_mode == 2'h1 && i_acc_valid && i_acc_debug |=> !o_acc_grant)
		else $error("debug access granted while protected");
	a_kill_debug_blocked: assert property (
		o_mode == 2'h2 && i_acc_valid && i_acc_debug |=> !o_acc_grant && !o_debug_enable)
		else $error("debug access granted in kill");
	a_load_before_debug: assert property (
		(!o_mode_valid && i_acc_valid && i_acc_debug ##1 !o_mode_valid) |-> !o_acc_grant)
		else $error("debug access granted before mode load");
	a_kill_stays_kill: assert property (o_mode_valid && o_mode == 2'h2 |=> o_mode == 2'h2)
		else $error("left kill mode");
	a_kill_no_erase: assert property (o_mode == 2'h2 |-> !o_flash_erase_row)
		else $error("erase running in kill");
	a_open_after_erase: assert property (
		o_mode_valid && prev_mode_reg == 2'h1 && o_mode == 2'h0 |-> full_reg)
		else $error("protected returned open without full erase");
	a_erase_all_rows: assert property ($fell(o_flash_erase_row) |-> erase_cnt_reg == 10'h200)
		else $error("erase sweep not 512 rows");
endmodule // flash_prot_ctrl_asserts

bind flash_prot_ctrl flash_prot_ctrl_asserts u_asserts (.*);

`default_nettype wire

/* File: bench/test_flash_prot_ctrl.sv */
// self-checking testbench for the flash protection controller
`timescale 1ns/1ns
`default_nettype none

module test_flash_prot_ctrl;
	typedef struct packed {logic dbg; logic wr; logic [8:0] row; logic grant;} row_case_t;

	logic        i_clk = 1'h0, i_rst_n = 1'h0, i_nv_ready, o_nv_rd_req, o_nv_wr_req;
	logic [1:0]  i_nv_mode, o_nv_wr_mode, o_mode, o_flash_wait_cycles;
	logic        i_req_protect = 1'h0, i_req_kill = 1'h0, i_req_open = 1'h0;
	logic        i_req_internal = 1'h0, i_row_set = 1'h0, i_row_set_rd = 1'h0;
	logic        i_row_set_wr = 1'h0, i_acc_valid = 1'h0, i_acc_debug = 1'h0;
	logic        i_acc_syscall = 1'h0, i_acc_write = 1'h0, i_acc_erase_all = 1'h0;
	logic        i_fetch_valid = 1'h0, o_fetch_valid, o_flash_rd, o_flash_wr;
	logic        o_flash_erase_row, o_acc_grant, o_acc_refused, o_mode_valid;
	logic        o_debug_enable, o_req_rejected;
	logic [8:0]  i_row_set_idx = 9'h000;
	logic [14:0] i_acc_addr = 15'h0000, i_fetch_addr = 15'h0000, o_flash_addr;
	logic [31:0] i_flash_rdata, o_fetch_data, o_rd_data;
	logic [3:0]  nv_dly = 4'h6;
	int          miscompares = 0, num_checks = 0, n, k;
	row_case_t   rows [8] = '{'{1'h1, 1'h0, 9'h000, 1'h1}, '{1'h1, 1'h1, 9'h000, 1'h1},
		'{1'h1, 1'h1, 9'h003, 1'h0}, '{1'h1, 1'h0, 9'h005, 1'h0},
		'{1'h0, 1'h0, 9'h003, 1'h1}, '{1'h0, 1'h1, 9'h005, 1'h1},
		'{1'h0, 1'h1, 9'h003, 1'h0}, '{1'h1, 1'h0, 9'h003, 1'h1}};

	flash_prot_ctrl dut (.*);
	flash_nv_model nv (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_dly(nv_dly),
		.i_rd_req(o_nv_rd_req), .i_wr_req(o_nv_wr_req), .i_wr_mode(o_nv_wr_mode),
		.o_mode(i_nv_mode), .o_ready(i_nv_ready));

	// array data follows the address so a wrong row shows in read data
	assign i_flash_rdata = {17'h0a5a5, o_flash_addr};
	always #25 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////
	task step; @(posedge i_clk); #5; endtask
	task chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin miscompares++; $display("[ERR] %0t flag mismatch", $time); end
	endtask
	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin miscompares++; $display("[ERR] %0t value mismatch", $time); end
	endtask
	task acc(input logic dbg, input logic wr, input logic er, input logic [14:0] a);
		{i_acc_debug, i_acc_syscall, i_acc_write, i_acc_erase_all} = {dbg, !dbg, wr, er};
		i_acc_addr = a;
		i_acc_valid = 1'h1;
		step;
		i_acc_valid = 1'h0;
	endtask
	task req(input logic p, input logic kl, input logic op);
		{i_req_protect, i_req_kill, i_req_open} = {p, kl, op};
		step;
		{i_req_protect, i_req_kill, i_req_open} = 3'h0;
		step;
	endtask
	task set_row(input logic [8:0] idx, input logic rd, input logic wr);
		{i_req_internal, i_row_set, i_row_set_idx, i_row_set_rd, i_row_set_wr} = {2'h3, idx, rd, wr};
		step;
		{i_req_internal, i_row_set} = 2'h0;
		step;
	endtask
	task wait_mode(input logic [1:0] m);
		for (n = 0; n < 100 && !(o_mode_valid === 1'h1 && o_mode === m); n++) step;
		chk_val(o_mode, m);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge i_clk);
		#5 i_rst_n = 1'h1;
		acc(1'h1, 1'h0, 1'h0, 15'h0000);
		chk_bit(o_acc_grant, 1'h0);
		wait_mode(2'h0);
		chk_bit(o_debug_enable, 1'h1);
		set_row(9'h003, 1'h0, 1'h1);
		set_row(9'h005, 1'h1, 1'h0);
		for (int i = 0; i < 8; i++) begin
			acc(rows[i].dbg, rows[i].wr, 1'h0, {rows[i].row, 6'h00});
			chk_bit(o_acc_grant, rows[i].grant);
			chk_bit(o_acc_refused, !rows[i].grant);
			chk_bit(o_flash_wr, rows[i].grant && rows[i].wr);
			step;
			if (rows[i].grant && !rows[i].wr)
				chk_val(o_rd_data, {17'h0a5a5, rows[i].row, 6'h00});
		end
		i_fetch_valid = 1'h1;
		step;
		i_fetch_valid = 1'h0;
		chk_bit(o_fetch_valid, 1'h1);
		chk_val(o_flash_wait_cycles, 2'h0);
		// array model echoes the last granted address, row 3
		chk_val(o_fetch_data, {17'h0a5a5, 15'h00c0});
		nv_dly = 4'h0;
		req(1'h1, 1'h0, 1'h0);
		wait_mode(2'h1);
		acc(1'h1, 1'h0, 1'h0, 15'h0000);
		chk_bit(o_acc_refused, 1'h1);
		step;
		acc(1'h0, 1'h0, 1'h0, 15'h0000);
		chk_bit(o_acc_grant, 1'h1);
		i_req_open = 1'h1;
		step;
		i_req_open = 1'h0;
		chk_bit(o_req_rejected, 1'h1);
		repeat (20) step;
		chk_val(o_mode, 2'h1);
		acc(1'h0, 1'h0, 1'h1, 15'h0000);
		// the sweep strobe rises one edge after the request is taken
		step;
		for (k = 0; o_flash_erase_row === 1'h1 && k < 600; k++) step;
		chk_val(k, 32'h200);
		wait_mode(2'h0);
		acc(1'h1, 1'h1, 1'h0, 15'h00c0);
		chk_bit(o_acc_grant, 1'h1);
		req(1'h0, 1'h1, 1'h0);
		wait_mode(2'h2);
		acc(1'h1, 1'h0, 1'h0, 15'h0000);
		chk_bit(o_acc_grant, 1'h0);
		step;
		acc(1'h1, 1'h0, 1'h1, 15'h0000);
		chk_bit(o_req_rejected, 1'h1);
		step;
		chk_bit(o_flash_erase_row, 1'h0);
		acc(1'h0, 1'h0, 1'h0, 15'h0000);
		chk_bit(o_acc_grant, 1'h1);
		req(1'h0, 1'h0, 1'h1);
		req(1'h1, 1'h0, 1'h0);
		chk_val(o_mode, 2'h2);
		i_rst_n = 1'h0;
		step;
		i_rst_n = 1'h1;
		wait_mode(2'h2);
		chk_bit(o_debug_enable, 1'h0);
		print_verdict;
	end

	initial begin
		#250000;
		miscompares++;
		print_verdict;
	end
endmodule // test_flash_prot_ctrl

`default_nettype wire
